// ### hdl/pilc_ctrl.sv
// Power-down, isolate and loopback control at the GMII and line side
`default_nettype none

module pilc_ctrl
    import pilc_pkg::*;
#(
    parameter bit HAS_MDIO = 1'b1,
    parameter bit IS_TBI   = 1'b0
)
(
    input  wire logic                  user_clock_125,
    input  wire logic                  rst,
    input  wire logic                  reg0_write,
    input  wire logic [REG0_WIDTH-1:0] reg0_wdata,
    output logic [REG0_WIDTH-1:0]      reg0_rdata,
    input  wire logic [CFGV_WIDTH-1:0] configuration_word,
    input  wire logic [7:0]            gmii_txd,
    input  wire logic                  gmii_tx_en,
    input  wire logic                  gmii_tx_er,
    output logic [7:0]                 gmii_rxd,
    output logic                       gmii_rx_dv,
    output logic                       gmii_rx_er,
    input  wire logic [9:0]            pcs_tx_code,
    output logic [9:0]                 pcs_rx_code,
    output logic [9:0]                 xcvr_tx_code,
    input  wire logic [9:0]            xcvr_rx_code,
    input  wire logic [7:0]            pcs_rxd,
    input  wire logic                  pcs_rx_dv,
    input  wire logic                  pcs_rx_er,
    output logic [7:0]                 pcs_txd,
    output logic                       pcs_tx_en,
    output logic                       pcs_tx_er,
    output logic                       powerdown,
    output logic                       isolated,
    output logic                       loopback_active,
    output logic                       wrap_request,
    output logic [1:0]                 xcvr_loop_select
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pilc_power_type power;
        logic           isolate;
        logic           loopback;
        logic [7:0]     rxd;
        logic           rx_dv;
        logic           rx_er;
        logic [7:0]     txd;
        logic           tx_en;
        logic           tx_er;
        logic [9:0]     rx_code;
        logic [9:0]     tx_code;
    } pilc_state_type;

    pilc_state_type state;
    pilc_state_type next_state;

    logic [REG0_WIDTH-1:0] reg0_value;
    logic                  soft_reset;
    logic [9:0]            idle_code;
    logic                  pd_request;
    logic                  iso_request;
    logic                  loop_request;

    pilc_reg0 u_reg0 (
        .clock      (user_clock_125),
        .rst        (rst),
        .write      (reg0_write & HAS_MDIO),
        .wdata      (reg0_wdata),
        .value      (reg0_value),
        .soft_reset (soft_reset)
    );

    pilc_idle_gen u_idle (
        .clock  (user_clock_125),
        .rst    (rst),
        .enable (1'b1),
        .code   (idle_code)
    );

    // ------------------------------------------------------------------
    // Source of control bits
    // ------------------------------------------------------------------
    always_comb begin
        if (HAS_MDIO) begin
            pd_request   = reg0_value[REG0_POWER_BIT];
            iso_request  = reg0_value[REG0_ISOLATE_BIT];
            loop_request = reg0_value[REG0_LOOPBACK_BIT];
        end else begin
            pd_request   = configuration_word[CFGV_POWER_BIT];
            iso_request  = configuration_word[CFGV_ISOLATE_BIT];
            loop_request = configuration_word[CFGV_LOOPBACK_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state.power)
            PILC_RUN: begin
                // TBI has no transceiver to power down
                if (pd_request && !IS_TBI) begin
                    next_state.power = PILC_LOW;
                end
            end
            PILC_LOW: begin
                // Only a reset leaves; clearing the bit is not enough
                if (soft_reset) begin
                    next_state.power = PILC_WAKE;
                end
            end
            PILC_WAKE: begin
                next_state.power = PILC_RUN;
            end
            default: begin
                next_state.power = PILC_RUN;
            end
        endcase

        next_state.isolate  = iso_request;
        next_state.loopback = loop_request;

        // Receive side toward the MAC and transmit side toward the PCS, blanked while isolated
        if (state.isolate) begin
            next_state.rxd   = GMII_DATA_IDLE;
            next_state.rx_dv = 1'b0;
            next_state.rx_er = 1'b0;
            next_state.txd   = GMII_DATA_IDLE;
            next_state.tx_en = 1'b0;
            next_state.tx_er = 1'b0;
        end else begin
            next_state.rxd   = pcs_rxd;
            next_state.rx_dv = pcs_rx_dv;
            next_state.rx_er = pcs_rx_er;
            next_state.txd   = gmii_txd;
            next_state.tx_en = gmii_tx_en;
            next_state.tx_er = gmii_tx_er;
        end

        // Line side: loop at the last point before the transceiver
        if (state.loopback && !IS_TBI) begin
            next_state.rx_code = pcs_tx_code;
            next_state.tx_code = idle_code;
        end else begin
            next_state.rx_code = xcvr_rx_code;
            next_state.tx_code = pcs_tx_code;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge user_clock_125) begin
        if (rst) begin
            state <= '{power:    PILC_RUN,
                       isolate:  1'b1,
                       loopback: 1'b0,
                       rxd:      GMII_DATA_IDLE,
                       rx_dv:    1'b0,
                       rx_er:    1'b0,
                       txd:      GMII_DATA_IDLE,
                       tx_en:    1'b0,
                       tx_er:    1'b0,
                       rx_code:  IDLE_K28_5_RDN,
                       tx_code:  IDLE_K28_5_RDN};
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg0_rdata       = reg0_value;
    assign gmii_rxd         = state.rxd;
    assign gmii_rx_dv       = state.rx_dv;
    assign gmii_rx_er       = state.rx_er;
    assign pcs_txd          = state.txd;
    assign pcs_tx_en        = state.tx_en;
    assign pcs_tx_er        = state.tx_er;
    assign pcs_rx_code      = state.rx_code;
    assign xcvr_tx_code     = state.tx_code;
    assign powerdown        = (state.power == PILC_LOW);
    assign isolated         = state.isolate;
    assign loopback_active  = state.loopback;
    assign wrap_request     = state.loopback & IS_TBI;
    assign xcvr_loop_select = LOOP_SEL_OFF;
endmodule : pilc_ctrl

`default_nettype wire

// ### hdl/pilc_idle_gen.sv
// Idle code group generator with running disparity alternation
`default_nettype none

module pilc_idle_gen
    import pilc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       enable,
    output logic [9:0]      code
);
    typedef struct packed {
        logic       second;
        logic [9:0] code;
    } pilc_idle_type;

    pilc_idle_type state;
    pilc_idle_type next_state;

    always_comb begin
        next_state = state;
        if (enable) begin
            next_state.second = ~state.second;
            next_state.code   = state.second ? IDLE_D16_2_RDP
                                             : IDLE_K28_5_RDN;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '{second: 1'b0, code: IDLE_K28_5_RDN};
        end else begin
            state <= next_state;
        end
    end

    assign code = state.code;
endmodule : pilc_idle_gen

`default_nettype wire

// ### hdl/pilc_pkg.sv
// Constants and types for the power, isolate and loopback control block
//
// How it works
// - With management present, setting the power-down control bit in configuration register zero puts the transceiver into low power.
// - With management present, low power is left only by the register-zero software reset bit or the core reset port.
// - Without management, the power-down bit of the static configuration word puts the transceiver into low power.
// - Without management, low power is left only on the core reset port; clearing power-down alone does not restore operation.
// - With management present, the block starts isolated and a write to register zero is needed to clear isolation.
// - Loopback is taken from the management register or from the configuration word, whichever option is built.
// - In the ten-bit variant, loopback drives the wrap request output high so the external SerDes loops the data.
// - In the transceiver variant, loopback feeds transmit data into the receive path just before the transceiver interface.
// - During internal loopback, a constant stream of Idle code groups goes out through the transceiver.
// - The two-bit transceiver loop-select output is tied to binary zero-zero at all times.
// - The whole GMII and the attached MAC run on the single 125 MHz user clock.
`default_nettype none

package pilc_pkg;
    // ------------------------------------------------------------------
    // Configuration register zero bit positions
    // ------------------------------------------------------------------
    localparam int REG0_RESET_BIT    = 15;
    localparam int REG0_LOOPBACK_BIT = 14;
    localparam int REG0_POWER_BIT    = 11;
    localparam int REG0_ISOLATE_BIT  = 10;
    localparam int REG0_WIDTH        = 16;

    // ------------------------------------------------------------------
    // Static configuration word bit positions
    // ------------------------------------------------------------------
    localparam int CFGV_LOOPBACK_BIT = 1;
    localparam int CFGV_POWER_BIT    = 2;
    localparam int CFGV_ISOLATE_BIT  = 3;
    localparam int CFGV_WIDTH        = 5;

    // ------------------------------------------------------------------
    // Code groups and fixed values
    // ------------------------------------------------------------------
    localparam logic [9:0] IDLE_K28_5_RDN = 10'h0FA;
    localparam logic [9:0] IDLE_D16_2_RDP = 10'h289;
    localparam logic [1:0] LOOP_SEL_OFF   = 2'h0;
    localparam logic [7:0] GMII_DATA_IDLE = 8'h00;
    localparam logic [15:0] REG0_RESET_VALUE = 16'h1140 | 16'h0400;

    typedef enum logic [2:0] {
        PILC_RUN   = 3'h1,
        PILC_LOW   = 3'h2,
        PILC_WAKE  = 3'h4
    } pilc_power_type;
endpackage : pilc_pkg

`default_nettype wire

// ### hdl/pilc_reg0.sv
// Configuration register zero with self-clearing software reset
`default_nettype none

module pilc_reg0
    import pilc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  write,
    input  wire logic [REG0_WIDTH-1:0] wdata,
    output logic [REG0_WIDTH-1:0]      value,
    output logic                       soft_reset
);
    typedef struct packed {
        logic [REG0_WIDTH-1:0] value;
        logic                  soft_reset;
    } pilc_reg0_type;

    pilc_reg0_type state;
    pilc_reg0_type next_state;

    always_comb begin
        next_state = state;
        next_state.soft_reset = 1'b0;
        if (write) begin
            next_state.value = wdata;
            next_state.value[REG0_RESET_BIT] = 1'b0;
            next_state.soft_reset = wdata[REG0_RESET_BIT];
        end
        if (state.soft_reset) begin
            next_state.value = REG0_RESET_VALUE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '{value: REG0_RESET_VALUE, soft_reset: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign value      = state.value;
    assign soft_reset = state.soft_reset;
endmodule : pilc_reg0

`default_nettype wire

// ### verif/pilc_ctrl_bench.sv
// Self-checking bench of the power, isolate and loopback control
`default_nettype none
module pilc_ctrl_bench
    import pilc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        user_clock_125;
    logic        rst        = 1'b1;
    logic        reg0_write = 1'b0;
    logic [15:0] reg0_wdata = 16'h0000;
    logic [4:0]  configuration_word = 5'h0E;
    logic [15:0] reg0_rdata;
    logic [7:0]  gmii_txd, gmii_rxd, pcs_rxd, pcs_txd;
    logic        gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er;
    logic        pcs_rx_dv, pcs_rx_er, pcs_tx_en, pcs_tx_er;
    logic [9:0]  pcs_tx_code, pcs_rx_code, xcvr_tx_code, xcvr_rx_code;
    logic        powerdown, isolated, loopback_active, wrap_request;
    logic [1:0]  xcvr_loop_select;
    logic [9:0]  e, x, r;
    logic [3:0]  f;
    // Isolate asserted from power-on by the client
    logic [4:0]  cfg_word = 5'h08;
    logic [9:0]  cfg_rx_code, tbi_rx_code;
    logic        cfg_powerdown, cfg_isolated, cfg_loopback;
    logic        tbi_powerdown, tbi_wrap;
    int          n_mismatch = 0;
    int          n_compared = 0;
    pilc_ctrl i_pilc_ctrl (.user_clock_125, .rst, .reg0_write, .reg0_wdata,
        .reg0_rdata, .configuration_word, .gmii_txd, .gmii_tx_en, .gmii_tx_er,
        .gmii_rxd, .gmii_rx_dv, .gmii_rx_er, .pcs_tx_code, .pcs_rx_code,
        .xcvr_tx_code, .xcvr_rx_code, .pcs_rxd, .pcs_rx_dv, .pcs_rx_er,
        .pcs_txd, .pcs_tx_en, .pcs_tx_er, .powerdown, .isolated,
        .loopback_active, .wrap_request, .xcvr_loop_select);
    pilc_far i_pilc_far (.user_clock_125, .gmii_txd, .gmii_tx_en, .gmii_tx_er,
        .pcs_rxd, .pcs_rx_dv, .pcs_rx_er, .pcs_tx_code, .xcvr_rx_code);
    // Variant without management: control bits from the static word
    pilc_ctrl #(.HAS_MDIO(1'b0), .IS_TBI(1'b0)) i_pilc_ctrl_cfg (
        .user_clock_125, .rst, .reg0_write, .reg0_wdata, .reg0_rdata (),
        .configuration_word (cfg_word), .gmii_txd, .gmii_tx_en,
        .gmii_tx_er, .gmii_rxd (), .gmii_rx_dv (), .gmii_rx_er (),
        .pcs_tx_code, .pcs_rx_code (cfg_rx_code), .xcvr_tx_code (),
        .xcvr_rx_code, .pcs_rxd, .pcs_rx_dv, .pcs_rx_er, .pcs_txd (),
        .pcs_tx_en (), .pcs_tx_er (), .powerdown (cfg_powerdown),
        .isolated (cfg_isolated), .loopback_active (cfg_loopback),
        .wrap_request (), .xcvr_loop_select ());
    // Ten-bit variant: loopback is asked of the external SerDes
    pilc_ctrl #(.HAS_MDIO(1'b1), .IS_TBI(1'b1)) i_pilc_ctrl_tbi (
        .user_clock_125, .rst, .reg0_write, .reg0_wdata, .reg0_rdata (),
        .configuration_word, .gmii_txd, .gmii_tx_en, .gmii_tx_er,
        .gmii_rxd (), .gmii_rx_dv (), .gmii_rx_er (), .pcs_tx_code,
        .pcs_rx_code (tbi_rx_code), .xcvr_tx_code (), .xcvr_rx_code,
        .pcs_rxd, .pcs_rx_dv, .pcs_rx_er, .pcs_txd (), .pcs_tx_en (),
        .pcs_tx_er (), .powerdown (tbi_powerdown), .isolated (),
        .loopback_active (), .wrap_request (tbi_wrap),
        .xcvr_loop_select ());
    task automatic check(logic [15:0] seen, logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h want=%h",
                     $time, seen, want);
        end
    endtask : check
    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // Register write, then settle past the two-cycle answer
    task automatic wr0(logic [15:0] v);
        @(posedge user_clock_125);
        reg0_write <= 1'b1;
        reg0_wdata <= v;
        @(posedge user_clock_125);
        reg0_write <= 1'b0;
        repeat (4) @(negedge user_clock_125);
    endtask : wr0
    // Static word change, then settle past the one-cycle answer
    task automatic set_cfg(logic [4:0] v);
        @(posedge user_clock_125);
        cfg_word <= v;
        repeat (3) @(negedge user_clock_125);
    endtask : set_cfg
    task automatic t_cfg;
        check(16'(cfg_isolated), 16'h0001);
        set_cfg(5'h02);
        check(16'(cfg_isolated), 16'h0000);
        check(16'(cfg_loopback), 16'h0001);
        e = pcs_tx_code;
        @(negedge user_clock_125);
        check(16'(cfg_rx_code), 16'(e));
        set_cfg(5'h04);
        check(16'(cfg_loopback), 16'h0000);
        check(16'(cfg_powerdown), 16'h0001);
        set_cfg(5'h00);
        check(16'(cfg_powerdown), 16'h0001);
    endtask : t_cfg
    task automatic t_pass;
        check(reg0_rdata, 16'h1540);
        check(16'(isolated), 16'h0001);
        check(16'(gmii_rx_dv), 16'h0000);
        check(16'(pcs_tx_en), 16'h0000);
        check(16'({gmii_rx_er, pcs_tx_er, pcs_txd}), 16'h0000);
        check(16'(powerdown), 16'h0000);
        wr0(16'h1140);
        check(reg0_rdata, 16'h1140);
        check(16'(isolated), 16'h0000);
        e = 10'(pcs_rxd);
        x = 10'(gmii_txd);
        f = {pcs_rx_dv, pcs_rx_er, gmii_tx_en, gmii_tx_er};
        @(negedge user_clock_125);
        check(16'(gmii_rxd), 16'(e));
        check(16'(pcs_txd), 16'(x));
        check(16'({gmii_rx_dv, gmii_rx_er, pcs_tx_en, pcs_tx_er}),
              16'(f));
    endtask : t_pass
    task automatic t_loop;
        wr0(16'h5140);
        check(16'(loopback_active), 16'h0001);
        check(16'(wrap_request), 16'h0000);
        check(16'(tbi_wrap), 16'h0001);
        e = pcs_tx_code;
        x = xcvr_tx_code;
        r = xcvr_rx_code;
        @(negedge user_clock_125);
        check(16'(pcs_rx_code), 16'(e));
        check(16'(tbi_rx_code), 16'(r));
        check(16'(xcvr_tx_code ^ x),
              16'(IDLE_K28_5_RDN ^ IDLE_D16_2_RDP));
        check(16'(xcvr_loop_select), 16'h0000);
        wr0(16'h1140);
        check(16'(loopback_active), 16'h0000);
        check(16'(tbi_wrap), 16'h0000);
    endtask : t_loop
    task automatic t_power;
        wr0(16'h1940);
        check(16'(powerdown), 16'h0001);
        check(16'(tbi_powerdown), 16'h0000);
        wr0(16'h1140);
        check(16'(powerdown), 16'h0001);
        wr0(16'h9140);
        check(16'(powerdown), 16'h0000);
        check(reg0_rdata, 16'h1540);
        check(16'(isolated), 16'h0001);
        check(16'(cfg_powerdown), 16'h0001);
        wr0(16'h1940);
        @(posedge user_clock_125);
        rst <= 1'b1;
        repeat (2) @(posedge user_clock_125);
        rst <= 1'b0;
        @(negedge user_clock_125);
        check(16'(powerdown), 16'h0000);
        check(16'(cfg_powerdown), 16'h0000);
        repeat (2) @(negedge user_clock_125);
        check(16'(isolated), 16'h0001);
        check(16'(powerdown), 16'h0000);
        check(16'(cfg_powerdown), 16'h0000);
    endtask : t_power
    initial begin
        user_clock_125 = 1'b0;
        forever #20 user_clock_125 = ~user_clock_125;
    end
    initial begin
        repeat (6) @(posedge user_clock_125);
        rst <= 1'b0;
        @(negedge user_clock_125);
        t_cfg();
        t_pass();
        t_loop();
        t_power();
        conclude();
    end
    initial begin
        repeat (1000) @(posedge user_clock_125);
        n_mismatch++;
        conclude();
    end
endmodule : pilc_ctrl_bench
`default_nettype wire

// ### verif/pilc_ctrl_sva.sv
// Assertions on the ports of the control block
`default_nettype none
module pilc_ctrl_sva
    import pilc_pkg::*;
#(
    parameter bit HAS_MDIO = 1'b1,
    parameter bit IS_TBI   = 1'b0
)
(
    input wire logic        user_clock_125,
    input wire logic        rst,
    input wire logic        reg0_write,
    input wire logic [15:0] reg0_wdata,
    input wire logic [9:0]  pcs_tx_code,
    input wire logic [9:0]  pcs_rx_code,
    input wire logic [9:0]  xcvr_tx_code,
    input wire logic [7:0]  pcs_rxd,
    input wire logic [7:0]  gmii_rxd,
    input wire logic        gmii_rx_dv,
    input wire logic        pcs_tx_en,
    input wire logic        powerdown,
    input wire logic        isolated,
    input wire logic        loopback_active,
    input wire logic        wrap_request,
    input wire logic [1:0]  xcvr_loop_select
);
    default clocking @(posedge user_clock_125); endclocking
    default disable iff (rst);
    logic soft_req;
    logic iso_bit;
    logic pwr_req;
    assign soft_req = reg0_write & reg0_wdata[REG0_RESET_BIT];
    assign iso_bit  = reg0_wdata[REG0_ISOLATE_BIT];
    assign pwr_req  = reg0_write & reg0_wdata[REG0_POWER_BIT] & ~soft_req;
    sequence loop_held;
        loopback_active ##1 loopback_active;
    endsequence
    a_sel_zero: assert property (xcvr_loop_select == LOOP_SEL_OFF)
        else $error("loop select not zero");
    a_wrap_level: assert property (
        wrap_request == (loopback_active & IS_TBI)) else $error("wrap bad");
    a_power_entry: assert property (
        HAS_MDIO && !IS_TBI && pwr_req |-> ##2 powerdown)
        else $error("no power down");
    a_power_hold: assert property (
        $fell(powerdown) |-> HAS_MDIO && $past(soft_req, 2) || $past(rst))
        else $error("power down left without reset");
    a_power_latch: assert property (
        !HAS_MDIO && powerdown |=> powerdown)
        else $error("power down left without core reset");
    a_iso_follow: assert property (
        HAS_MDIO && reg0_write && !soft_req |->
        ##2 isolated == $past(iso_bit, 2)) else $error("isolate lag");
    a_iso_quiet: assert property (
        isolated |=> !gmii_rx_dv && !pcs_tx_en && gmii_rxd == GMII_DATA_IDLE)
        else $error("isolated outputs active");
    a_rx_pass: assert property (
        !isolated ##1 !isolated |-> gmii_rxd == $past(pcs_rxd))
        else $error("receive data lost");
    a_loop_path: assert property (
        loop_held |-> IS_TBI || pcs_rx_code == $past(pcs_tx_code))
        else $error("loop path broken");
    a_idle_out: assert property (
        loop_held ##1 loopback_active |-> IS_TBI ||
        (xcvr_tx_code != $past(xcvr_tx_code)
        && (xcvr_tx_code inside {IDLE_K28_5_RDN, IDLE_D16_2_RDP})))
        else $error("no idle stream");
endmodule : pilc_ctrl_sva
bind pilc_ctrl pilc_ctrl_sva #(.HAS_MDIO(HAS_MDIO), .IS_TBI(IS_TBI)) i_sva (
    .user_clock_125, .rst, .reg0_write, .reg0_wdata, .pcs_tx_code,
    .pcs_rx_code, .xcvr_tx_code, .pcs_rxd, .gmii_rxd, .gmii_rx_dv,
    .pcs_tx_en, .powerdown, .isolated, .loopback_active, .wrap_request,
    .xcvr_loop_select);
`default_nettype wire

// ### verif/pilc_far.sv
// Stand-in for the MAC and the line-side transceiver traffic
`default_nettype none
module pilc_far (
    input  wire logic user_clock_125,
    output logic [7:0] gmii_txd,
    output logic       gmii_tx_en,
    output logic       gmii_tx_er,
    output logic [7:0] pcs_rxd,
    output logic       pcs_rx_dv,
    output logic       pcs_rx_er,
    output logic [9:0] pcs_tx_code,
    output logic [9:0] xcvr_rx_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] cnt = 10'h000;
    // One clock for both directions: no crossing on the GMII
    always_ff @(posedge user_clock_125) begin
        cnt <= cnt + 10'h001;
    end
    // Values other than the two error bits change every cycle so a stuck path cannot pass
    assign gmii_txd     = cnt[7:0] ^ 8'hA5;
    assign gmii_tx_en   = cnt[0];
    assign gmii_tx_er   = cnt[3];
    assign pcs_rxd      = cnt[7:0];
    assign pcs_rx_dv    = ~cnt[0];
    assign pcs_rx_er    = cnt[4];
    assign pcs_tx_code  = cnt + 10'h155;
    assign xcvr_rx_code = ~cnt;
endmodule : pilc_far
`default_nettype wire
